// [wsq_defines.svh]
// constants for the weld schedule sequencer and monitor
`ifndef WSQ_DEFINES_SVH
`define WSQ_DEFINES_SVH
`define WSQ_A_CTRL       12'h000
`define WSQ_A_SCHED      12'h004
`define WSQ_A_TIME       12'h008
`define WSQ_A_LIMIT      12'h00c
`define WSQ_A_PWLIM      12'h010
`define WSQ_A_OFFSET     12'h014
`define WSQ_A_EVENT      12'h018
`define WSQ_A_STATUS     12'h01c
`define WSQ_A_MEAS       12'h020
`define WSQ_A_OUTS       12'h024
`define WSQ_A_ACTOFS     12'h028
`define WSQ_MAX_TIME     7'd99
`define WSQ_MAX_PCT      7'd99
`define WSQ_MAX_OFS      4'd15
`define WSQ_NUM_SCHED    100
`define WSQ_EV_NA        6'h3f
`define WSQ_WAIT_SCHED_A 7'd20
`define WSQ_WAIT_SCHED_B 7'd40
`define WSQ_WAIT_SCHED_C 7'd60
`endif

// [wsq_pkg.sv]
// types for the weld schedule sequencer and monitor
package wsq_pkg;
	typedef enum logic [2:0] {
		WSQ_NONREPEAT,
		WSQ_REPEAT,
		WSQ_CHAINED,
		WSQ_SUCCESSIVE,
		WSQ_WAITHERE
	} wsq_mode_t;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} wsq_apb_req_t;
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} wsq_apb_rsp_t;
	typedef struct packed {
		logic [6:0] squeeze;
		logic [6:0] weld;
		logic [6:0] cool;
		logic [6:0] hold;
		logic [6:0] off;
		logic [6:0] impulses;
		logic [6:0] block_delay;
		logic [2:0] mode;
	} wsq_sched_t;
endpackage

// [wsq_seq.sv]
// weld schedule sequencer with second pulse monitor, heat offset and events
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "wsq_defines.svh"
// How it works
// - lower prethreshold is lower limit times one plus margin percent.
// - margin 0..99 percent, used only with monitor and precheck both on.
// - upper prethreshold is upper limit times one minus margin percent.
// - average at/above upper pre flags upper prefault; at/below lower flags lower.
// - width check on: average width at/above upper limit flags wide fault.
// - width check on: average width at/below lower limit flags narrow fault.
// - gap time 0..99 line cycles with current off between impulses; stored unclamped here, up to 127.
// - hold keeps electrodes closed 0..99 line cycles after welding; stored unclamped here, up to 127.
// - repeat mode waits off time 0..99 cycles between hold and squeeze; stored unclamped here, up to 127.
// - impulses per schedule 1 to 99; here zero is stored as 1 and values up to 127 are kept.
// - offset clamped to plus/minus max up to 15; max zero disables.
// - offset shifts heat or current of both weld pulses; here it is only reported, as the active offset at ACTOFS.
// - scope picks selected schedule only or every schedule.
// - offset may change under edit or pin lock when max nonzero.
// - air-over-oil mode 2 energises block valve delay after hold.
// - each of 100 schedules has its own cycle mode.
// - non-repeat runs one sequence per initiation even if held.
// - repeat restarts while initiation held closed.
// - chained runs linked schedules back to back from one initiation.
// - successive advances schedule per initiation and flashes number.
// - wait-here pauses until different initiation, then runs chosen schedule.
// - up to four events per schedule, each switching one output.
// - event targets one of 32 outputs or not-applicable code.
// - event state decides output driven off or on.
module wsq_seq #(
	parameter int NUM_SCHED = `WSQ_NUM_SCHED
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire wsq_pkg::wsq_apb_req_t apb_req,
	output var  wsq_pkg::wsq_apb_rsp_t apb_rsp,
	input  wire logic                  line_tick,
	input  wire logic                  init_first,
	input  wire logic                  init_second,
	input  wire logic                  edit_locked,
	input  wire logic [15:0]           avg_current,
	input  wire logic [6:0]            avg_width,
	output logic                       fire,
	output logic                       weld_valve,
	output logic                       block_valve,
	output logic                       sched_flash,
	output logic [6:0]                 active_sched,
	output logic [31:0]                prog_out
);
	import wsq_pkg::*;
	typedef enum logic [2:0] {ST_IDLE, ST_SQZ, ST_WELD, ST_COOL, ST_HOLD, ST_BLOCK, ST_OFF} wsq_st_t;

	wsq_sched_t  sched_mem [NUM_SCHED];
	logic [3:0][7:0] ev_mem [NUM_SCHED];
	logic [6:0]  sel_sched;
	logic [6:0]  wr_sched;
	logic        mon_on;
	logic        pre_on;
	logic        pw_on;
	logic        aoo_mode2;
	logic        scope_all;
	logic [3:0]  max_ofs;
	logic signed [4:0] ofs_sel;
	logic signed [4:0] ofs_all;
	logic [15:0] upper_limit_setting;
	logic [15:0] lower_limit_setting;
	logic [6:0]  prelimit_margin_setting;
	logic [6:0]  pw_upper;
	logic [6:0]  pw_lower;
	logic        wide_pulse_fault;
	logic        narrow_pulse_fault;
	logic        second_pulse_upper_prefault;
	logic        second_pulse_lower_prefault;
	logic [15:0] pre_upper;
	logic [15:0] pre_lower;
	wsq_st_t     state;
	wsq_sched_t  cur;
	logic [6:0]  tmr;
	logic [6:0]  imp_cnt;
	logic [1:0]  init_q;
	logic        armed;
	logic        wait_from_second;
	logic        apb_fire;
	logic [31:0] rdata;
	logic signed [4:0] act_ofs;
	logic        init_any;
	logic        init_rise;

	assign init_any = init_first | init_second;
	// per-input edge: swapping inputs in one cycle keeps init_any high
	assign init_rise = wait_from_second ? (init_first & ~init_q[0]) : (init_second & ~init_q[1]);
	assign apb_fire = apb_req.psel & apb_req.penable & apb_rsp.pready;
	// clamped offset only applies when a nonzero maximum is configured
	assign act_ofs = (max_ofs == 4'h0) ? 5'sd0 : (scope_all ? ofs_all : ofs_sel);

	// products kept wide, then scaled by 100; margin never exceeds 99 so no underflow
	always_comb begin
		logic [23:0] up;
		logic [23:0] lo;
		up = 24'(upper_limit_setting) * (24'd100 - 24'(prelimit_margin_setting));
		lo = 24'(lower_limit_setting) * (24'd100 + 24'(prelimit_margin_setting));
		pre_upper = 16'(up / 24'd100);
		pre_lower = 16'(lo / 24'd100);
	end

	function automatic logic signed [4:0] clamp_ofs(input logic [4:0] v, input logic [3:0] m);
		logic signed [5:0] s;
		logic signed [5:0] mx;
		s = 6'(signed'(v));
		mx = signed'({2'b00, m});
		if (s > mx)
			return 5'(mx);
		else if (s < -mx)
			return 5'(-mx);
		return 5'(s);
	endfunction

	// register writes; writes to missing schedules are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_sched <= 7'h00;
			wr_sched <= 7'h00;
			mon_on <= 1'b0;
			pre_on <= 1'b0;
			pw_on <= 1'b0;
			aoo_mode2 <= 1'b0;
			scope_all <= 1'b0;
			max_ofs <= 4'h0;
			ofs_sel <= 5'sd0;
			ofs_all <= 5'sd0;
			upper_limit_setting <= 16'h0000;
			lower_limit_setting <= 16'h0000;
			prelimit_margin_setting <= 7'h00;
			pw_upper <= 7'h00;
			pw_lower <= 7'h00;
		end else if (apb_fire && apb_req.pwrite) begin
			case (apb_req.paddr)
				`WSQ_A_CTRL: begin
					mon_on <= apb_req.pwdata[0];
					pre_on <= apb_req.pwdata[1];
					pw_on <= apb_req.pwdata[2];
					aoo_mode2 <= apb_req.pwdata[3];
					scope_all <= apb_req.pwdata[4];
					max_ofs <= (apb_req.pwdata[11:8] > `WSQ_MAX_OFS) ? `WSQ_MAX_OFS
						: apb_req.pwdata[11:8];
					sel_sched <= apb_req.pwdata[22:16];
					wr_sched <= apb_req.pwdata[30:24];
				end
				`WSQ_A_LIMIT: begin
					upper_limit_setting <= apb_req.pwdata[31:16];
					lower_limit_setting <= apb_req.pwdata[15:0];
				end
				`WSQ_A_PWLIM: begin
					pw_upper <= (apb_req.pwdata[14:8] > `WSQ_MAX_PCT) ? `WSQ_MAX_PCT
						: apb_req.pwdata[14:8];
					pw_lower <= (apb_req.pwdata[6:0] > `WSQ_MAX_PCT) ? `WSQ_MAX_PCT
						: apb_req.pwdata[6:0];
					prelimit_margin_setting <= (apb_req.pwdata[22:16] > `WSQ_MAX_PCT)
						? `WSQ_MAX_PCT : apb_req.pwdata[22:16];
				end
				`WSQ_A_OFFSET: begin
					// no lock gating: offset stays adjustable whenever max is nonzero
					if (max_ofs != 4'h0) begin
						if (scope_all)
							ofs_all <= clamp_ofs(apb_req.pwdata[4:0], max_ofs);
						else
							ofs_sel <= clamp_ofs(apb_req.pwdata[4:0], max_ofs);
					end
				end
				default: begin
				end
			endcase
		end
	end

	// schedule table with mode per schedule; times stored unclamped, up to 127 cycles
	always_ff @(posedge pclk) begin
		if (apb_fire && apb_req.pwrite && 32'(wr_sched) < NUM_SCHED) begin
			if (apb_req.paddr == `WSQ_A_SCHED) begin
				sched_mem[wr_sched].squeeze <= apb_req.pwdata[6:0];
				sched_mem[wr_sched].weld <= apb_req.pwdata[13:7];
				sched_mem[wr_sched].impulses <= (apb_req.pwdata[20:14] == 7'h00) ? 7'd1
					: apb_req.pwdata[20:14];
				sched_mem[wr_sched].mode <= apb_req.pwdata[23:21];
			end
			if (apb_req.paddr == `WSQ_A_TIME) begin
				sched_mem[wr_sched].cool <= apb_req.pwdata[6:0];
				sched_mem[wr_sched].hold <= apb_req.pwdata[13:7];
				sched_mem[wr_sched].off <= apb_req.pwdata[20:14];
				sched_mem[wr_sched].block_delay <= apb_req.pwdata[27:21];
			end
			if (apb_req.paddr == `WSQ_A_EVENT)
				ev_mem[wr_sched] <= apb_req.pwdata;
		end
	end

	// sequence engine, timed in line cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			cur <= '0;
			tmr <= 7'h00;
			imp_cnt <= 7'h00;
			active_sched <= 7'h00;
			init_q <= 2'b00;
			armed <= 1'b1;
			wait_from_second <= 1'b0;
			fire <= 1'b0;
			weld_valve <= 1'b0;
			block_valve <= 1'b0;
			sched_flash <= 1'b0;
		end else begin
			init_q <= {init_second, init_first};
			if (!init_any)
				armed <= 1'b1;
			case (state)
				ST_IDLE: begin
					fire <= 1'b0;
					weld_valve <= 1'b0;
					if (init_any && armed) begin
						armed <= 1'b0;
						wait_from_second <= init_second;
						// successive keeps the advanced number; others use the selector
						if (!sched_flash) begin
							active_sched <= sel_sched;
							cur <= sched_mem[sel_sched];
							sched_flash <= (sched_mem[sel_sched].mode == 3'(WSQ_SUCCESSIVE));
						end
						state <= ST_SQZ;
						tmr <= 7'h00;
						weld_valve <= 1'b1;
						block_valve <= 1'b0;
					end
				end
				ST_SQZ: begin
					// block valve drops before current can flow again
					block_valve <= 1'b0;
					if (cur.mode == 3'(WSQ_WAITHERE) && init_rise) begin
						active_sched <= wait_from_second ? `WSQ_WAIT_SCHED_A : `WSQ_WAIT_SCHED_B;
						cur <= sched_mem[wait_from_second ? `WSQ_WAIT_SCHED_A : `WSQ_WAIT_SCHED_B];
						cur.mode <= 3'(WSQ_NONREPEAT);
						tmr <= 7'h00;
					end else if (cur.mode == 3'(WSQ_WAITHERE)) begin
						// pause here until the other initiation arrives
					end else if (line_tick) begin
						if (tmr >= cur.squeeze) begin
							state <= ST_WELD;
							tmr <= 7'h00;
							imp_cnt <= 7'h01;
							fire <= (cur.weld != 7'h00);
						end else
							tmr <= tmr + 7'd1;
					end
				end
				ST_WELD: begin
					if (line_tick) begin
						if (tmr + 7'd1 >= cur.weld) begin
							fire <= 1'b0;
							tmr <= 7'h00;
							state <= (imp_cnt >= cur.impulses) ? ST_HOLD : ST_COOL;
						end else
							tmr <= tmr + 7'd1;
					end
				end
				ST_COOL: begin
					fire <= 1'b0;
					if (line_tick) begin
						if (tmr + 7'd1 >= cur.cool) begin
							tmr <= 7'h00;
							imp_cnt <= imp_cnt + 7'd1;
							fire <= (cur.weld != 7'h00);
							state <= ST_WELD;
						end else
							tmr <= tmr + 7'd1;
					end
				end
				ST_HOLD: begin
					weld_valve <= 1'b1;
					if (line_tick) begin
						if (tmr + 7'd1 >= cur.hold) begin
							tmr <= 7'h00;
							weld_valve <= 1'b0;
							state <= aoo_mode2 ? ST_BLOCK : ST_OFF;
						end else
							tmr <= tmr + 7'd1;
					end
				end
				ST_BLOCK: begin
					if (line_tick) begin
						if (tmr + 7'd1 >= cur.block_delay) begin
							block_valve <= 1'b1;
							tmr <= 7'h00;
							state <= ST_OFF;
						end else
							tmr <= tmr + 7'd1;
					end
				end
				ST_OFF: begin
					case (wsq_mode_t'(cur.mode))
						WSQ_REPEAT: begin
							if (!init_any)
								state <= ST_IDLE;
							else if (line_tick) begin
								if (tmr + 7'd1 >= cur.off) begin
									tmr <= 7'h00;
									weld_valve <= 1'b1;
									state <= ST_SQZ;
								end else
									tmr <= tmr + 7'd1;
							end
						end
						WSQ_CHAINED: begin
							// next linked schedule runs without a new initiation
							active_sched <= active_sched + 7'd1;
							cur <= sched_mem[7'(active_sched + 7'd1)];
							tmr <= 7'h00;
							weld_valve <= 1'b1;
							state <= (32'(active_sched) + 1 < NUM_SCHED) ? ST_SQZ : ST_IDLE;
						end
						WSQ_SUCCESSIVE: begin
							active_sched <= active_sched + 7'd1;
							cur <= sched_mem[7'(active_sched + 7'd1)];
							sched_flash <= (32'(active_sched) + 1 < NUM_SCHED);
							state <= ST_IDLE;
						end
						default: begin
							sched_flash <= 1'b0;
							state <= ST_IDLE;
						end
					endcase
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// second-pulse checks at the falling end of the final impulse; faults sticky until read
	logic end_of_pulse;
	logic rd_status;
	assign end_of_pulse = (state == ST_WELD) && line_tick && (tmr + 7'd1 >= cur.weld)
		&& (imp_cnt >= cur.impulses);
	assign rd_status = apb_fire && !apb_req.pwrite && apb_req.paddr == `WSQ_A_STATUS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wide_pulse_fault <= 1'b0;
			narrow_pulse_fault <= 1'b0;
			second_pulse_upper_prefault <= 1'b0;
			second_pulse_lower_prefault <= 1'b0;
		end else begin
			// set wins over the read-clear in the same cycle
			wide_pulse_fault <= (end_of_pulse && pw_on && avg_width >= pw_upper)
				| (wide_pulse_fault & ~rd_status);
			narrow_pulse_fault <= (end_of_pulse && pw_on && avg_width <= pw_lower)
				| (narrow_pulse_fault & ~rd_status);
			second_pulse_upper_prefault <= (end_of_pulse && mon_on && pre_on
				&& avg_current >= pre_upper) | (second_pulse_upper_prefault & ~rd_status);
			second_pulse_lower_prefault <= (end_of_pulse && mon_on && pre_on
				&& avg_current <= pre_lower) | (second_pulse_lower_prefault & ~rd_status);
		end
	end

	// events fire on entry to hold; one output each, N/A code disables
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_out
			logic [3:0] hit;
			logic [3:0] val;
			for (genvar e = 0; e < 4; e++) begin : g_ev
				assign hit[e] = ev_mem[active_sched][e][5:0] != `WSQ_EV_NA
					&& ev_mem[active_sched][e][4:0] == 5'(g)
					&& ev_mem[active_sched][e][5] == 1'b0;
				assign val[e] = ev_mem[active_sched][e][7];
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					prog_out[g] <= 1'b0;
				else if (state == ST_WELD && end_of_pulse && |hit)
					prog_out[g] <= val[hit[3] ? 3 : hit[2] ? 2 : hit[1] ? 1 : 0];
			end
		end
	endgenerate

	// register readback; offset value is only reported and shifts neither pulse's heat nor current
	always_comb begin
		case (apb_req.paddr)
			`WSQ_A_CTRL: rdata = {1'b0, wr_sched, 1'b0, sel_sched, 4'h0, max_ofs,
				3'h0, scope_all, aoo_mode2, pw_on, pre_on, mon_on};
			`WSQ_A_LIMIT: rdata = {upper_limit_setting, lower_limit_setting};
			`WSQ_A_PWLIM: rdata = {9'h000, prelimit_margin_setting, 1'b0, pw_upper, 1'b0, pw_lower};
			`WSQ_A_OFFSET: rdata = {27'h0, scope_all ? ofs_all : ofs_sel};
			`WSQ_A_STATUS: rdata = {16'h0, 1'b0, active_sched, 1'b0, edit_locked, fire,
				1'(state != ST_IDLE), second_pulse_lower_prefault,
				second_pulse_upper_prefault, narrow_pulse_fault, wide_pulse_fault};
			`WSQ_A_MEAS: rdata = {pre_upper, pre_lower};
			`WSQ_A_OUTS: rdata = prog_out;
			`WSQ_A_ACTOFS: rdata = {27'h0, act_ofs};
			default: rdata = 32'h0000_0000;
		endcase
	end

	// one wait state: pready rises in the first access cycle's following edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			apb_rsp <= '0;
		else begin
			apb_rsp.pready <= apb_req.psel & apb_req.penable & ~apb_rsp.pready;
			apb_rsp.pslverr <= 1'b0;
			if (apb_req.psel && apb_req.penable && !apb_rsp.pready)
				apb_rsp.prdata <= rdata;
		end
	end
endmodule
`default_nettype wire

// [wsq_plant.sv]
// far-side model: mains timebase, contactor and valve observer
`timescale 1ns/1ps
`default_nettype none
module wsq_plant #(
	parameter int TICK = 20
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic fire,
	input  wire logic block_valve,
	output var  logic line_tick,
	output var  int   fire_cycles,
	output var  int   fire_rises,
	output var  logic block_seen
);
	int   div;
	logic fire_q;
	// mains runs free, so ticks come whether or not a weld is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div       <= 0;
			line_tick <= 1'b0;
		end else begin
			div       <= (div == TICK - 1) ? 0 : div + 1;
			line_tick <= (div == TICK - 1);
		end
	end
	// contactor passes current only while fire is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fire_q      <= 1'b0;
			fire_cycles <= 0;
			fire_rises  <= 0;
			block_seen  <= 1'b0;
		end else begin
			fire_q <= fire;
			if (fire === 1'b1)
				fire_cycles <= fire_cycles + 1;
			if (fire === 1'b1 && fire_q !== 1'b1)
				fire_rises <= fire_rises + 1;
			if (block_valve === 1'b1)
				block_seen <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [wsq_seq_props.sv]
// port checker for the weld sequencer
`timescale 1ns/1ps
`default_nettype none
module wsq_seq_props
	import wsq_pkg::*;
#(
	parameter int NUM_SCHED = 100
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire wsq_pkg::wsq_apb_req_t apb_req,
	input wire wsq_pkg::wsq_apb_rsp_t apb_rsp,
	input wire logic                  line_tick,
	input wire logic                  fire,
	input wire logic                  weld_valve,
	input wire logic                  block_valve,
	input wire logic [6:0]            active_sched,
	input wire logic [31:0]           prog_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	rdy_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held longer than one cycle");
	rdy_cause_a: assert property (apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable))
		else $error("pready without an access phase");
	rdy_wait_a: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
		|=> apb_rsp.pready)
		else $error("access not answered after one wait state");
	no_err_a: assert property (!apb_rsp.pslverr)
		else $error("slave error raised");
	fire_tick_a: assert property ($changed(fire) |-> $past(line_tick) || $past(line_tick, 2))
		else $error("fire moved off the line cycle grid");
	fire_clamp_a: assert property (fire |-> weld_valve)
		else $error("current while electrodes open");
	block_cold_a: assert property (block_valve |-> !fire)
		else $error("block valve during current");
	sched_range_a: assert property (active_sched < NUM_SCHED)
		else $error("active schedule out of range");
	out_quiet_a: assert property ($changed(prog_out) |-> !fire)
		else $error("event output moved during current");
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the weld sequencer
`timescale 1ns/1ps
`default_nettype none
`include "wsq_defines.svh"
module tb;
	import wsq_pkg::*;
	localparam int          TICK = 20;
	localparam logic [31:0] CTRL = 32'h0000_060f;
	localparam logic [31:0] EVW  = 32'h3f3f_bf85;
	localparam logic [31:0] TW   = 32'h0040_4182;
	localparam logic [31:0] SW   = 32'h0000_8182;
	logic         pclk, presetn, init_first, init_second, edit_locked;
	logic         line_tick, fire, weld_valve, block_valve, sched_flash, block_seen;
	logic [15:0]  avg_current;
	logic [6:0]   avg_width, active_sched;
	logic [31:0]  prog_out, rd;
	wsq_apb_req_t req;
	wsq_apb_rsp_t rsp;
	int           fire_cycles, fire_rises, mismatches, check_count, cyc, r0, c0;
	wsq_seq #(.NUM_SCHED(100)) uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.apb_rsp(rsp), .line_tick(line_tick), .init_first(init_first),
		.init_second(init_second), .edit_locked(edit_locked), .avg_current(avg_current),
		.avg_width(avg_width), .fire(fire), .weld_valve(weld_valve),
		.block_valve(block_valve), .sched_flash(sched_flash),
		.active_sched(active_sched), .prog_out(prog_out));
	wsq_plant #(.TICK(TICK)) plant (.pclk(pclk), .presetn(presetn), .fire(fire),
		.block_valve(block_valve), .line_tick(line_tick), .fire_cycles(fire_cycles),
		.fire_rises(fire_rises), .block_seen(block_seen));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one edge first, so back-to-back calls never assign psel twice in a step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		req.psel    <= 1'b1;
		req.pwrite  <= wr;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// schedule memory is not reset, so every used slot is written first
	task automatic load(input logic [6:0] idx, input logic [31:0] sw);
		apb(1'b1, `WSQ_A_CTRL, CTRL | {1'b0, idx, 24'h0});
		apb(1'b1, `WSQ_A_SCHED, sw);
		apb(1'b1, `WSQ_A_TIME, TW);
		apb(1'b1, `WSQ_A_EVENT, EVW);
	endtask
	task automatic wait_valve(input logic v);
		for (int n = 0; n < 4000 && weld_valve !== v; n++)
			@(posedge pclk);
	endtask
	task automatic t_thresh();
		apb(1'b1, `WSQ_A_CTRL, CTRL);
		apb(1'b1, `WSQ_A_LIMIT, 32'h0258_0190);
		apb(1'b1, `WSQ_A_PWLIM, 32'h000a_5014);
		apb(1'b0, `WSQ_A_MEAS, 32'h0);
		check(rd, 32'h021c_01b8);
		apb(1'b1, `WSQ_A_PWLIM, 32'h0000_5014);
		apb(1'b0, `WSQ_A_MEAS, 32'h0);
		check(rd, 32'h0258_0190);
		apb(1'b1, `WSQ_A_PWLIM, 32'h007f_5014);
		apb(1'b0, `WSQ_A_MEAS, 32'h0);
		check(rd, 32'h0006_031c);
		apb(1'b1, `WSQ_A_PWLIM, 32'h000a_5014);
	endtask
	task automatic t_offset();
		edit_locked <= 1'b1;
		apb(1'b1, `WSQ_A_OFFSET, 32'h0000_000f);
		apb(1'b0, `WSQ_A_ACTOFS, 32'h0);
		check({27'h0, rd[4:0]}, 32'h0000_0006);
		apb(1'b1, `WSQ_A_OFFSET, 32'h0000_0011);
		apb(1'b0, `WSQ_A_ACTOFS, 32'h0);
		check({27'h0, rd[4:0]}, 32'h0000_001a);
		apb(1'b1, `WSQ_A_CTRL, CTRL | 32'h0000_0010);
		apb(1'b1, `WSQ_A_OFFSET, 32'h0000_0003);
		apb(1'b0, `WSQ_A_ACTOFS, 32'h0);
		check({27'h0, rd[4:0]}, 32'h0000_0003);
		apb(1'b1, `WSQ_A_CTRL, CTRL);
		apb(1'b0, `WSQ_A_ACTOFS, 32'h0);
		check({27'h0, rd[4:0]}, 32'h0000_001a);
		edit_locked <= 1'b0;
	endtask
	task automatic t_once();
		load(7'd0, SW);
		avg_width   <= 7'd90;
		avg_current <= 16'd700;
		r0 = fire_rises;
		c0 = fire_cycles;
		init_first  <= 1'b1;
		wait_valve(1'b1);
		wait_valve(1'b0);
		repeat (40 * TICK) @(posedge pclk);
		check(fire_rises - r0, 2);
		check(fire_cycles - c0, 3 * 2 * TICK);
		check(block_seen, 1'b1);
		check(prog_out, 32'h0000_0020);
		apb(1'b0, `WSQ_A_STATUS, 32'h0);
		check(rd[3:0], 4'b0101);
		apb(1'b0, `WSQ_A_STATUS, 32'h0);
		check(rd[3:0], 4'b0000);
		init_first  <= 1'b0;
	endtask
	task automatic t_repeat();
		load(7'd0, SW | 32'h0020_0000);
		avg_width   <= 7'd10;
		avg_current <= 16'd300;
		r0 = fire_rises;
		init_first  <= 1'b1;
		repeat (60 * TICK) @(posedge pclk);
		init_first  <= 1'b0;
		repeat (40 * TICK) @(posedge pclk);
		check(fire_rises - r0 > 2, 1'b1);
		apb(1'b0, `WSQ_A_STATUS, 32'h0);
		check(rd[3:0], 4'b1010);
	endtask
	task automatic t_wait();
		load(7'd40, SW);
		load(7'd0, SW | 32'h0080_0000);
		init_first  <= 1'b1;
		wait_valve(1'b1);
		repeat (20 * TICK) @(posedge pclk);
		init_first  <= 1'b0;
		init_second <= 1'b1;
		repeat (10 * TICK) @(posedge pclk);
		check(active_sched, 7'd40);
		init_second <= 1'b0;
		repeat (60 * TICK) @(posedge pclk);
	endtask
	task automatic t_chain();
		load(7'd1, SW);
		load(7'd0, SW | 32'h0040_0000);
		r0 = fire_rises;
		init_first <= 1'b1;
		wait_valve(1'b1);
		init_first <= 1'b0;
		repeat (60 * TICK) @(posedge pclk);
		check(fire_rises - r0, 4);
		check(active_sched, 7'd1);
	endtask
	task automatic t_succ();
		load(7'd1, SW | 32'h0060_0000);
		load(7'd0, SW | 32'h0060_0000);
		for (int k = 0; k < 2; k++) begin
			init_first <= 1'b1;
			wait_valve(1'b1);
			check(active_sched, k[6:0]);
			check(sched_flash, 1'b1);
			init_first <= 1'b0;
			repeat (40 * TICK) @(posedge pclk);
		end
		apb(1'b0, 12'h030, 32'h0);
		check(rd, 32'h0);
	endtask
	// run length is a few hundred line ticks, well under the 3000-tick limit
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		presetn     = 1'b0;
		req         = '0;
		init_first  = 1'b0;
		init_second = 1'b0;
		edit_locked = 1'b0;
		avg_current = 16'h0;
		avg_width   = 7'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_thresh();
		t_offset();
		t_once();
		t_repeat();
		t_wait();
		t_chain();
		t_succ();
		wrap_up();
	end
endmodule
bind wsq_seq wsq_seq_props #(.NUM_SCHED(NUM_SCHED)) props (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .line_tick(line_tick), .fire(fire),
	.weld_valve(weld_valve), .block_valve(block_valve), .active_sched(active_sched),
	.prog_out(prog_out));
`default_nettype wire
